// file: posq_sequencer.sv
// stored data positioning sequencer: start handshake, entry table, move launch
`timescale 1ns/1ps
module posq_sequencer
  import posq_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // host discrete inputs
  input wire logic servo_on_i,
  input wire logic start_i,
  input wire logic [POSQ_SEL_W-1:0] data_select_inputs_i,
  // entry table write port
  input wire logic entry_we_i,
  input wire logic [POSQ_SEL_W-1:0] entry_addr_i,
  input wire posq_entry_t entry_data_i,
  // wrap configuration
  input wire posq_wrap_t wrap_cfg_i,
  // positions from the motion loop
  input wire logic signed [31:0] cmd_pos_i,
  input wire logic signed [31:0] fb_pos_i,
  input wire logic move_done_i,
  // host discrete outputs
  output logic ready_o,
  output logic alarm_o,
  // move command
  output logic move_start_o,
  output posq_move_t move_o,
  output logic [POSQ_SEL_W-1:0] active_entry_o
);

  typedef enum logic [1:0] {
    POSQ_IDLE,
    POSQ_MOVE,
    POSQ_RELEASE,
    POSQ_FAULT
  } posq_state_t;

  posq_state_t state_q;
  posq_entry_t table_q [POSQ_ENTRIES];
  posq_entry_t sel_entry;
  logic [POSQ_SEL_W-1:0] sel_num;
  logic signed [31:0] calc_target;
  logic signed [63:0] calc_travel;
  logic wrap_bad;
  logic is_wrap;
  logic travel_bad;
  logic accept;
  logic entry_bad;
  logic launch;

  // selected entry number, input 0 as lsb
  assign sel_num = data_select_inputs_i;
  assign sel_entry = table_q[sel_num];
  assign is_wrap = (sel_entry.optype == POSQ_OP_WRAP_ABS) ||
                   (sel_entry.optype == POSQ_OP_WRAP_NEAR) ||
                   (sel_entry.optype == POSQ_OP_WRAP_FWD);
  assign travel_bad = (calc_travel > POSQ_MAX_TRAVEL) || (calc_travel < -POSQ_MAX_TRAVEL);
  // host must hold servo-on and see ready before start
  assign accept = (state_q == POSQ_IDLE) && ready_o && servo_on_i && start_i;
  // refused entry: travel out of range or wrap not usable
  assign entry_bad = travel_bad || (is_wrap && wrap_bad);
  // accepted and not refused: the move goes out
  assign launch = accept && !entry_bad;

  posq_target posq_target_i (
    .entry_i(sel_entry),
    .cmd_pos_i(cmd_pos_i),
    .fb_pos_i(fb_pos_i),
    .wrap_i(wrap_cfg_i),
    .target_o(calc_target),
    .travel_o(calc_travel),
    .wrap_bad_o(wrap_bad)
  );

  // entry table storage, one entry per data number
  always_ff @(posedge clock_i) begin
    if (entry_we_i) begin
      table_q[entry_addr_i] <= entry_data_i;
    end
  end

  // handshake state
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= POSQ_IDLE;
    end else begin
      unique case (state_q)
        POSQ_IDLE: begin
          if (accept) begin
            if (entry_bad) begin
              state_q <= POSQ_FAULT;
            end else begin
              state_q <= POSQ_MOVE;
            end
          end
        end
        POSQ_MOVE: begin
          if (move_done_i || !servo_on_i) begin
            state_q <= POSQ_RELEASE;
          end
        end
        POSQ_RELEASE: begin
          if (!start_i) begin
            state_q <= POSQ_IDLE;
          end
        end
        POSQ_FAULT: begin
          if (!servo_on_i) begin
            state_q <= POSQ_IDLE;
          end
        end
      endcase
    end
  end

  // ready: low on accept, high after completion once start is released
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else if (accept) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= servo_on_i && (state_q == POSQ_IDLE ||
                 (state_q == POSQ_RELEASE && !start_i));
    end
  end

  // operation data error alarm, cleared by servo-off
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_o <= 1'b0;
    end else if (accept && entry_bad) begin
      alarm_o <= 1'b1;
    end else if (state_q == POSQ_FAULT && !servo_on_i) begin
      alarm_o <= 1'b0;
    end
  end

  // move command latched only on a launch, a refused entry leaves it alone
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      move_start_o <= 1'b0;
      move_o <= '0;
      active_entry_o <= '0;
    end else begin
      move_start_o <= launch;
      if (launch) begin
        move_o.target <= calc_target;
        move_o.travel <= calc_travel[31:0];
        move_o.speed <= sel_entry.speed[31] ? -sel_entry.speed : sel_entry.speed;
        move_o.acc_rate <= sel_entry.acc_rate;
        move_o.dec_rate <= sel_entry.dec_rate;
        active_entry_o <= sel_num;
      end
    end
  end

endmodule

// file: posq_pkg.sv
// package: types and constants for the positioning operation sequencer
// Notes on behaviour
// - on an accepted start the device drops ready and begins the selected entry.
// - when the move completes the device raises ready again.
// - incremental on command position adds the signed entry position to the command position.
// - incremental on feedback position adds the signed entry position to the feedback position.
// - the feedback reference is the measured value at start, even if it differs from command.
// - wrap absolute treats the entry position as a coordinate inside the wrap range from home.
// - wrap proximity turns in whichever direction reaches the wrapped target sooner.
// - wrap forward always moves forward to the wrapped target.
// - wrap types need the wrap function enabled, with a range in revs and an offset in percent.
// - each entry holds type, position in steps, speed in Hz, start/change rate and stop rate.
// - absolute mode takes the entry position as the target measured from home.
// - the select inputs form an unsigned number 0..255, input 0 the least significant bit.
// - a travel beyond 2,147,483,647 steps raises an operation-data error alarm.
package posq_pkg;

  localparam int unsigned POSQ_ENTRIES = 256;
  localparam int unsigned POSQ_SEL_W = 8;
  localparam logic [31:0] POSQ_STEPS_PER_REV_RST = 32'h0000_03E8; // 1000 steps a rev
  localparam logic [7:0] POSQ_WRAP_REVS_RST = 8'h12; // 18 rev
  localparam logic [6:0] POSQ_WRAP_OFS_PCT_RST = 7'h32; // 50 %
  localparam logic [6:0] POSQ_PCT_FULL = 7'h64; // 100 %
  localparam logic signed [63:0] POSQ_MAX_TRAVEL = 64'sh0000_0000_7FFF_FFFF;
  localparam logic [31:0] POSQ_SPEED_RST = 32'h0000_07D0; // 2,000 Hz
  localparam logic [15:0] POSQ_RATE_RST = 16'h05DC; // 1.500 kHz/s in Hz/s units

  // positioning types
  typedef enum logic [2:0] {
    POSQ_OP_ABS,
    POSQ_OP_INC_CMD,
    POSQ_OP_INC_FB,
    POSQ_OP_WRAP_ABS,
    POSQ_OP_WRAP_NEAR,
    POSQ_OP_WRAP_FWD
  } posq_op_t;

  // one stored data entry
  typedef struct packed {
    posq_op_t optype;
    logic signed [31:0] position; // steps
    logic [31:0] speed; // Hz
    logic [15:0] acc_rate; // Hz/s
    logic [15:0] dec_rate; // Hz/s
  } posq_entry_t;

  // wrap configuration
  typedef struct packed {
    logic enable;
    logic manual;
    logic [7:0] revs;
    logic [6:0] ofs_pct;
    logic [31:0] steps_per_rev;
  } posq_wrap_t;

  // motion command towards the profile generator
  typedef struct packed {
    logic signed [31:0] target;
    logic signed [31:0] travel;
    logic [31:0] speed;
    logic [15:0] acc_rate;
    logic [15:0] dec_rate;
  } posq_move_t;

endpackage

// file: posq_target.sv
// target and travel calculation for one stored data entry
`timescale 1ns/1ps
module posq_target
  import posq_pkg::*;
(
  // entry and references
  input wire posq_entry_t entry_i,
  input wire logic signed [31:0] cmd_pos_i,
  input wire logic signed [31:0] fb_pos_i,
  input wire posq_wrap_t wrap_i,
  // result
  output logic signed [31:0] target_o,
  output logic signed [63:0] travel_o,
  output logic wrap_bad_o
);

  logic signed [63:0] span;
  logic signed [63:0] lo;
  logic signed [63:0] tgt;
  logic signed [63:0] cur;
  logic signed [63:0] fwd;

  // floor modulo into [0, span)
  function automatic logic signed [63:0] posq_mod(input logic signed [63:0] v,
                                                   input logic signed [63:0] m);
    logic signed [63:0] r;
    r = v % m;
    if (r < 0) begin
      r = r + m;
    end
    return r;
  endfunction

  // wrap range bounds from revs and offset percent
  always_comb begin
    span = 64'(wrap_i.revs) * 64'(wrap_i.steps_per_rev);
    lo = -((span * 64'(wrap_i.ofs_pct)) / 64'(POSQ_PCT_FULL));
    wrap_bad_o = 1'b0;
    if (!wrap_i.enable || !wrap_i.manual || span == 64'sd0) begin
      wrap_bad_o = 1'b1;
    end
  end

  // per-type target and signed travel
  always_comb begin
    cur = 64'(cmd_pos_i);
    tgt = 64'(entry_i.position);
    fwd = 64'sd0;
    unique case (entry_i.optype)
      POSQ_OP_ABS: tgt = 64'(entry_i.position);
      POSQ_OP_INC_CMD: tgt = 64'(cmd_pos_i) + 64'(entry_i.position);
      POSQ_OP_INC_FB: begin
        cur = 64'(fb_pos_i);
        tgt = 64'(fb_pos_i) + 64'(entry_i.position);
      end
      POSQ_OP_WRAP_ABS, POSQ_OP_WRAP_NEAR, POSQ_OP_WRAP_FWD: begin
        if (span != 64'sd0) begin
          cur = posq_mod(64'(cmd_pos_i) - lo, span) + lo;
          tgt = posq_mod(64'(entry_i.position) - lo, span) + lo;
          fwd = posq_mod(tgt - cur, span);
        end
      end
      default: tgt = 64'(entry_i.position);
    endcase
    travel_o = tgt - cur;
    if (entry_i.optype == POSQ_OP_WRAP_NEAR) begin
      travel_o = (fwd * 2 <= span) ? fwd : fwd - span;
    end else if (entry_i.optype == POSQ_OP_WRAP_FWD) begin
      travel_o = fwd;
    end
    target_o = tgt[31:0];
  end

endmodule

// file: posq_monitor.sv
// checker: handshake and launch properties at the sequencer ports
`timescale 1ns/1ps
module posq_monitor
  import posq_pkg::*;
(
  // watched ports
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic servo_on_i,
  input wire logic start_i,
  input wire logic move_done_i,
  input wire logic ready_o,
  input wire logic alarm_o,
  input wire logic move_start_o,
  input wire posq_move_t move_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // accept, launch pulse and ready return
  accept_drop_a: assert property (ready_o && servo_on_i && start_i |=> !ready_o)
    else $error("ready kept after start");
  accept_go_a: assert property (ready_o && servo_on_i && start_i |=> move_start_o || alarm_o)
    else $error("no launch after start");
  go_cause_a: assert property (move_start_o |-> $past(ready_o) && $past(start_i))
    else $error("launch without start");
  go_pulse_a: assert property (move_start_o |=> !move_start_o)
    else $error("launch pulse too long");
  ready_wait_a: assert property (move_start_o && !move_done_i |=> !ready_o)
    else $error("ready back before done");
  ready_back_a: assert property (
    !ready_o && move_done_i && !start_i && servo_on_i && !alarm_o |-> ##[1:2] ready_o)
    else $error("ready not back after done");
  ready_rise_a: assert property ($rose(ready_o) |-> !$past(start_i))
    else $error("ready rose with start high");
  alarm_hold_a: assert property (alarm_o && servo_on_i |=> alarm_o)
    else $error("alarm dropped");
  cmd_hold_a: assert property (!move_start_o |-> $stable(move_o))
    else $error("move command changed");
endmodule

bind posq_sequencer posq_monitor posq_monitor_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .servo_on_i(servo_on_i), .start_i(start_i), .move_done_i(move_done_i), .ready_o(ready_o),
  .alarm_o(alarm_o), .move_start_o(move_start_o), .move_o(move_o));

// file: posq_host.sv
// host model: servo-on, entry select, start handshake and move completion
`timescale 1ns/1ps
module posq_host (
  // clock and device status
  input wire logic clock_i,
  input wire logic ready_i,
  // discrete host lines
  output logic servo_on_o = 1'b0,
  output logic start_o = 1'b0,
  output logic [7:0] sel_o = 8'h00,
  output logic done_o = 1'b0
);
  // servo-on level change, then settle
  task automatic power(input logic v);
    servo_on_o = v;
    repeat (2) @(negedge clock_i);
  endtask
  // one start handshake, then completion after lag cycles
  task automatic launch(input logic [7:0] n, input int lag);
    int k;
    for (k = 0; k < 50 && ready_i !== 1'b1; k++) @(negedge clock_i);
    sel_o = n;
    start_o = 1'b1;
    @(negedge clock_i);
    for (k = 0; k < 50 && ready_i !== 1'b0; k++) @(negedge clock_i);
    start_o = 1'b0;
    sel_o = ~n; // released select lines do not keep the value
    repeat (lag) @(negedge clock_i);
    done_o = 1'b1;
    @(negedge clock_i);
    done_o = 1'b0;
  endtask
endmodule

// file: posq_sequencer_tb_top.sv
// testbench: entry table, target checks and alarm cases
`timescale 1ns/1ps
module posq_sequencer_tb_top;
  import posq_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic servo_on_i, start_i, move_done_i, entry_we_i, ready_o, alarm_o, move_start_o;
  logic [7:0] data_select_inputs_i, entry_addr_i, active_entry_o;
  posq_entry_t entry_data_i;
  posq_wrap_t wrap_cfg_i;
  posq_move_t move_o;
  logic signed [31:0] cmd_pos_i, fb_pos_i;
  integer seed = 32'ha30d532f;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [71:0] exp_q[$];
  // speed magnitude and rates every launched move must carry
  localparam logic [71:0] EXP_RATES = {8'h00, POSQ_SPEED_RST, POSQ_RATE_RST, POSQ_RATE_RST};
  logic [71:0] got_rates;
  assign got_rates = {8'h00, move_o.speed, move_o.acc_rate, move_o.dec_rate};
  // design and host model
  posq_sequencer posq_sequencer_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .servo_on_i(servo_on_i), .start_i(start_i), .data_select_inputs_i(data_select_inputs_i),
    .entry_we_i(entry_we_i), .entry_addr_i(entry_addr_i), .entry_data_i(entry_data_i),
    .wrap_cfg_i(wrap_cfg_i), .cmd_pos_i(cmd_pos_i), .fb_pos_i(fb_pos_i),
    .move_done_i(move_done_i), .ready_o(ready_o), .alarm_o(alarm_o),
    .move_start_o(move_start_o), .move_o(move_o), .active_entry_o(active_entry_o));
  posq_host posq_host_i (.clock_i(clock_i), .ready_i(ready_o), .servo_on_o(servo_on_i),
    .start_o(start_i), .sel_o(data_select_inputs_i), .done_o(move_done_i));
  // clock and hang limit
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [71:0] exp, input logic [71:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // oldest note against each launched move
  always @(negedge clock_i) begin
    if (move_start_o === 1'b1) begin
      if (exp_q.size() == 0) check("launch", 72'h0, 72'h1);
      else check("move", exp_q.pop_front(), {move_o.target, move_o.travel, active_entry_o});
      check("rates", EXP_RATES, got_rates);
    end
  end
  task automatic put(input logic [7:0] n, input posq_op_t op, input logic [31:0] pos);
    entry_addr_i = n;
    // odd entries get a negative speed, the launch must show its magnitude
    entry_data_i = '{op, pos, n[0] ? -POSQ_SPEED_RST : POSQ_SPEED_RST, POSQ_RATE_RST,
                     POSQ_RATE_RST};
    entry_we_i = 1'b1;
    @(negedge clock_i);
    entry_we_i = 1'b0;
  endtask
  task automatic run(input logic [7:0] n, input posq_op_t op, input logic [31:0] pos,
                     input logic [31:0] tgt, input logic [31:0] trv);
    put(n, op, pos);
    exp_q.push_back({tgt, trv, n});
    posq_host_i.launch(n, $random(seed) & 7);
    $display("test entry %0d done", n);
  endtask
  task automatic fail(input logic [7:0] n, input posq_op_t op, input logic [31:0] pos);
    put(n, op, pos);
    posq_host_i.launch(n, 0);
    check("alarm set", 72'h1, {71'h0, alarm_o});
    posq_host_i.power(1'b0);
    check("alarm clear", 72'h0, {71'h0, alarm_o});
    check("ready off", 72'h0, {71'h0, ready_o});
    posq_host_i.power(1'b1);
    $display("alarm test %0d done", n);
  endtask
  // main sequence
  initial begin
    entry_we_i = 1'b0;
    entry_addr_i = 8'h00;
    entry_data_i = '0;
    wrap_cfg_i = '{1'b1, 1'b1, POSQ_WRAP_REVS_RST, POSQ_WRAP_OFS_PCT_RST, POSQ_STEPS_PER_REV_RST};
    cmd_pos_i = 32'sh0000_0064;
    fb_pos_i = 32'sh0000_0064;
    repeat (10) @(negedge clock_i);
    rst_n_i = 1'b1;
    posq_host_i.power(1'b1);
    run(8'h00, POSQ_OP_ABS, 32'h0000_2198, 32'h0000_2198, 32'h0000_2134);
    cmd_pos_i = $random(seed) >>> 12;
    fb_pos_i = $random(seed) >>> 12;
    run(8'hFF, POSQ_OP_INC_CMD, 32'h0000_2134, cmd_pos_i + 32'h0000_2134, 32'h0000_2134);
    run(8'h5A, POSQ_OP_INC_FB, 32'h0000_2134, fb_pos_i + 32'h0000_2134, 32'h0000_2134);
    cmd_pos_i = 32'sh0000_0064;
    run(8'h01, POSQ_OP_WRAP_ABS, 32'h0000_2198, 32'h0000_2198, 32'h0000_2134);
    run(8'h80, POSQ_OP_WRAP_NEAR, 32'hFFFF_E0C0, 32'hFFFF_E0C0, 32'hFFFF_E05C);
    run(8'h7F, POSQ_OP_WRAP_FWD, 32'hFFFF_E0C0, 32'hFFFF_E0C0, 32'h0000_26AC);
    fail(8'h22, POSQ_OP_INC_CMD, 32'h8000_0000);
    wrap_cfg_i.enable = 1'b0;
    fail(8'h33, POSQ_OP_WRAP_ABS, 32'h0000_2198);
    repeat (5) @(negedge clock_i);
    check("pending", 72'h0, 72'(exp_q.size()));
    close_out();
  end
endmodule
